// ==== logic/dcs_ctrl_end.sv ====
// controller end: spaces commands and drives clock gate and write data
//
// Notes on behaviour
// - two idle cycles after write burst before read
// - clock gate held for three registered edges
// - no clock gate change within two cycles
// - capture fault blocks all reads until a write burst finishes
// - picosecond spacings round up to whole cycles
// - autoprecharge delay is recovery plus precharge cycles
// - every spacing counts real clock edges
// - activate no sooner than two edges after exit
// - mode bit ten set selects single-ended strobe
// - mode bit ten clear selects differential strobe
`timescale 1ns/100ps
module dcs_ctrl_end
  import dcs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  dcs_link_if.ctrl link,
  input wire logic req_valid,
  input wire logic [CMD_W-1:0] req_cmd,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [WR_BEATS*DATA_W-1:0] req_wdata,
  output logic req_ready,
  input wire logic cke_req,
  output logic cke_ready,
  output logic rewrite_pending,
  output logic strobe_single_ended
);

  // ----------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DCS_IDLE = 2'b01,
    DCS_BURST = 2'b10
  } dcs_ctrl_state_t;

  dcs_ctrl_state_t state_reg;
  logic cke_reg;
  logic [CMD_W-1:0] cmd_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] dq_reg;
  logic dqs_t_reg;
  logic [WR_BEATS*DATA_W-1:0] wdata_reg;
  logic [$clog2(WR_BEATS+1)-1:0] beat_reg;
  logic auto_pre_reg;
  logic strobe_se_reg;
  logic [MODE_WR_W-1:0] wr_field_reg;
  logic rewrite_reg;
  logic [CNT_W-1:0] cke_cnt_reg;
  logic [CNT_W-1:0] xp_cnt_reg;
  logic [CNT_W-1:0] wtr_cnt_reg;
  logic [CNT_W-1:0] rp_cnt_reg;
  logic [CNT_W-1:0] dal_cnt_reg;
  logic cmd_ok;
  logic cke_change;
  logic accept;
  logic burst_end;

  // ----------------------------------------------------------------
  // command gating
  // ----------------------------------------------------------------
  always_comb begin
    case (req_cmd)
      CMD_ACT: cmd_ok = (xp_cnt_reg == '0) && (rp_cnt_reg == '0)
                        && (dal_cnt_reg == '0);
      CMD_RD: cmd_ok = (wtr_cnt_reg == '0) && !rewrite_reg;
      default: cmd_ok = 1'b1;
    endcase
  end

  // gate changes only between bursts so no burst straddles power-down
  assign cke_ready = (cke_cnt_reg == '0) && (state_reg == DCS_IDLE);
  assign cke_change = cke_ready && (cke_req != cke_reg);
  assign req_ready = (state_reg == DCS_IDLE) && cke_reg && !cke_change
                     && cmd_ok;
  assign accept = req_valid && req_ready;
  assign burst_end = (state_reg == DCS_BURST)
                     && (beat_reg == ($bits(beat_reg))'(WR_BEATS - 1));

  // ----------------------------------------------------------------
  // clock gate and power-down exit
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cke_reg <= 1'b0;
      cke_cnt_reg <= '0;
      xp_cnt_reg <= '0;
    end else begin
      cke_cnt_reg <= cnt_step(cke_cnt_reg);
      xp_cnt_reg <= cnt_step(xp_cnt_reg);
      if (cke_change) begin
        cke_reg <= cke_req;
        cke_cnt_reg <= CNT_W'(CLOCK_GATE_MIN_WINDOW - 1);
        if (cke_req) begin
          xp_cnt_reg <= CNT_W'(POWERDOWN_EXIT_DELAY - 1);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // command issue and write burst
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= DCS_IDLE;
      cmd_reg <= CMD_NOP;
      addr_reg <= '0;
      wdata_reg <= '0;
      beat_reg <= '0;
      auto_pre_reg <= 1'b0;
      dq_reg <= '0;
      dqs_t_reg <= 1'b0;
    end else begin
      cmd_reg <= accept ? req_cmd : CMD_NOP;
      if (accept) begin
        addr_reg <= req_addr;
      end
      case (state_reg)
        DCS_IDLE: begin
          dqs_t_reg <= 1'b0;
          if (accept && (req_cmd == CMD_WR || req_cmd == CMD_WRA)) begin
            state_reg <= DCS_BURST;
            wdata_reg <= req_wdata;
            beat_reg <= '0;
            auto_pre_reg <= (req_cmd == CMD_WRA);
          end
        end
        DCS_BURST: begin
          dq_reg <= wdata_reg[beat_reg*DATA_W +: DATA_W];
          dqs_t_reg <= ~beat_reg[0];
          beat_reg <= beat_reg + 1'b1;
          if (burst_end) begin
            state_reg <= DCS_IDLE;
          end
        end
        default: state_reg <= DCS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // spacing counters, one per constraint
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wtr_cnt_reg <= '0;
      rp_cnt_reg <= '0;
      dal_cnt_reg <= '0;
    end else begin
      wtr_cnt_reg <= cnt_step(wtr_cnt_reg);
      rp_cnt_reg <= cnt_step(rp_cnt_reg);
      dal_cnt_reg <= cnt_step(dal_cnt_reg);
      if (burst_end) begin
        wtr_cnt_reg <= CNT_W'(WRITE_TO_READ_TURNAROUND);
        if (auto_pre_reg) begin
          dal_cnt_reg <= autoprecharge_write_delay(wr_field_reg);
        end
      end
      if (accept && req_cmd == CMD_PRE) begin
        rp_cnt_reg <= CNT_W'(PRECHARGE_PERIOD_CYCLES - 1);
      end
    end
  end

  // ----------------------------------------------------------------
  // mode shadow and rewrite tracking
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      strobe_se_reg <= MODE_STROBE_SE_RESET;
      wr_field_reg <= MODE_WR_RESET;
    end else if (accept && req_cmd == CMD_MODE) begin
      strobe_se_reg <= req_addr[MODE_STROBE_SE_BIT];
      wr_field_reg <= req_addr[MODE_WR_LSB +: MODE_WR_W];
    end
  end

  // a fault report outranks the clear from a finishing rewrite
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rewrite_reg <= 1'b0;
    end else if (link.capt_err) begin
      rewrite_reg <= 1'b1;
    end else if (burst_end) begin
      rewrite_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // link drive
  // ----------------------------------------------------------------
  assign link.cke = cke_reg;
  assign link.cmd = cmd_reg;
  assign link.addr = addr_reg;
  assign link.dq = dq_reg;
  assign link.dqs_t = dqs_t_reg;
  // complement parked low in single-ended mode
  assign link.dqs_c = strobe_se_reg ? 1'b0 : ~dqs_t_reg;
  assign rewrite_pending = rewrite_reg;
  assign strobe_single_ended = strobe_se_reg;

endmodule

// ==== common/dcs_pkg.sv ====
// constants, command codes and helpers shared by both link ends
package dcs_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int PRECHARGE_PERIOD_PS = 15000;
  localparam int WRITE_TO_READ_TURNAROUND = 2;
  localparam int CLOCK_GATE_MIN_WINDOW = 3;
  localparam int POWERDOWN_EXIT_DELAY = 2;
  localparam int CNT_W = 5;

  // least times round up, never below one cycle
  function automatic int spacing_cycle_count(input int t_ps,
                                             input int per_ps);
    int n;
    n = (t_ps + per_ps - 1) / per_ps;
    return (n < 1) ? 1 : n;
  endfunction

  localparam int PRECHARGE_PERIOD_CYCLES =
    spacing_cycle_count(PRECHARGE_PERIOD_PS, CLK_PERIOD_PS);

  // ----------------------------------------------------------------
  // link widths and command codes
  // ----------------------------------------------------------------
  localparam int ADDR_W = 14;
  localparam int DATA_W = 8;
  localparam int WR_BEATS = 2;
  localparam int CMD_W = 3;
  localparam logic [CMD_W-1:0] CMD_NOP = 3'h0;
  localparam logic [CMD_W-1:0] CMD_ACT = 3'h1;
  localparam logic [CMD_W-1:0] CMD_RD = 3'h2;
  localparam logic [CMD_W-1:0] CMD_WR = 3'h3;
  localparam logic [CMD_W-1:0] CMD_WRA = 3'h4;
  localparam logic [CMD_W-1:0] CMD_PRE = 3'h5;
  localparam logic [CMD_W-1:0] CMD_MODE = 3'h6;

  // ----------------------------------------------------------------
  // mode_config_register fields carried on the address lines
  // ----------------------------------------------------------------
  localparam int MODE_STROBE_SE_BIT = 10;
  localparam int MODE_WR_LSB = 11;
  localparam int MODE_WR_W = 3;
  localparam logic [MODE_WR_W-1:0] MODE_WR_RESET = 3'h3;
  localparam logic MODE_STROBE_SE_RESET = 1'b0;

  // write recovery setting is field plus one cycle
  function automatic logic [CNT_W-1:0] autoprecharge_write_delay(
      input logic [MODE_WR_W-1:0] wr_field);
    return CNT_W'(wr_field) + CNT_W'(1)
         + CNT_W'(PRECHARGE_PERIOD_CYCLES);
  endfunction

  function automatic logic [CNT_W-1:0] cnt_step(
      input logic [CNT_W-1:0] c);
    return (c == '0) ? c : c - CNT_W'(1);
  endfunction

endpackage

// ==== common/dcs_link_if.sv ====
// command link between the memory controller end and the device end
`timescale 1ns/100ps
interface dcs_link_if;
  import dcs_pkg::*;
  logic cke;
  logic [CMD_W-1:0] cmd;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dq;
  logic dqs_t;
  logic dqs_c;
  logic capt_err;

  modport ctrl (
    output cke,
    output cmd,
    output addr,
    output dq,
    output dqs_t,
    output dqs_c,
    input capt_err
  );

  modport dev (
    input cke,
    input cmd,
    input addr,
    input dq,
    input dqs_t,
    input dqs_c,
    output capt_err
  );
endinterface

// ==== logic/dcs_dev_end.sv ====
// device end: captures write data and flags spacing and capture faults
`timescale 1ns/100ps
module dcs_dev_end
  import dcs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  dcs_link_if.dev link,
  output logic [DATA_W-1:0] wr_data,
  output logic wr_valid,
  output logic spacing_err,
  output logic data_suspect,
  output logic strobe_single_ended,
  output logic [MODE_WR_W-1:0] wr_recovery
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic cke_q_reg;
  logic strobe_se_reg;
  logic [MODE_WR_W-1:0] wr_field_reg;
  logic [$clog2(WR_BEATS+1)-1:0] beats_left_reg;
  logic [$clog2(WR_BEATS+1)-1:0] beat_idx_reg;
  logic auto_pre_reg;
  logic burst_bad_reg;
  logic [DATA_W-1:0] wr_data_reg;
  logic wr_valid_reg;
  logic capt_err_reg;
  logic spacing_err_reg;
  logic suspect_reg;
  logic [CNT_W-1:0] cke_cnt_reg;
  logic [CNT_W-1:0] xp_cnt_reg;
  logic [CNT_W-1:0] wtr_cnt_reg;
  logic [CNT_W-1:0] rp_cnt_reg;
  logic [CNT_W-1:0] dal_cnt_reg;
  logic in_burst;
  logic last_beat;
  logic beat_bad;
  logic spacing_hit;

  // ----------------------------------------------------------------
  // capture check
  // ----------------------------------------------------------------
  assign in_burst = (beats_left_reg != '0);
  assign last_beat = (beats_left_reg == ($bits(beats_left_reg))'(1));
  // single-ended looks at the true strobe only
  assign beat_bad = (link.dqs_t != ~beat_idx_reg[0])
                    || (!strobe_se_reg && link.dqs_c == link.dqs_t);

  assign spacing_hit =
      ((link.cke != cke_q_reg) && (cke_cnt_reg != '0))
    || ((link.cmd == CMD_ACT) && ((xp_cnt_reg != '0) || (rp_cnt_reg != '0)
                                  || (dal_cnt_reg != '0)))
    || ((link.cmd == CMD_RD) && (wtr_cnt_reg != '0));

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      beats_left_reg <= '0;
      beat_idx_reg <= '0;
      auto_pre_reg <= 1'b0;
      burst_bad_reg <= 1'b0;
      wr_data_reg <= '0;
      wr_valid_reg <= 1'b0;
      capt_err_reg <= 1'b0;
    end else begin
      wr_valid_reg <= 1'b0;
      capt_err_reg <= 1'b0;
      if (in_burst) begin
        wr_data_reg <= link.dq;
        wr_valid_reg <= 1'b1;
        beats_left_reg <= beats_left_reg - 1'b1;
        beat_idx_reg <= beat_idx_reg + 1'b1;
        burst_bad_reg <= burst_bad_reg | beat_bad;
        capt_err_reg <= last_beat && (burst_bad_reg | beat_bad);
      end else if (link.cmd == CMD_WR || link.cmd == CMD_WRA) begin
        beats_left_reg <= ($bits(beats_left_reg))'(WR_BEATS);
        beat_idx_reg <= '0;
        burst_bad_reg <= 1'b0;
        auto_pre_reg <= (link.cmd == CMD_WRA);
      end
    end
  end

  // stored data stays suspect until a clean rewrite; a new fault wins
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      suspect_reg <= 1'b0;
    end else if (in_burst && last_beat && (burst_bad_reg | beat_bad)) begin
      suspect_reg <= 1'b1;
    end else if (in_burst && last_beat) begin
      suspect_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // mode capture
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      strobe_se_reg <= MODE_STROBE_SE_RESET;
      wr_field_reg <= MODE_WR_RESET;
    end else if (link.cmd == CMD_MODE) begin
      strobe_se_reg <= link.addr[MODE_STROBE_SE_BIT];
      wr_field_reg <= link.addr[MODE_WR_LSB +: MODE_WR_W];
    end
  end

  // ----------------------------------------------------------------
  // spacing watch, counted on real edges
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cke_q_reg <= 1'b0;
      cke_cnt_reg <= '0;
      xp_cnt_reg <= '0;
      wtr_cnt_reg <= '0;
      rp_cnt_reg <= '0;
      dal_cnt_reg <= '0;
      spacing_err_reg <= 1'b0;
    end else begin
      cke_q_reg <= link.cke;
      cke_cnt_reg <= cnt_step(cke_cnt_reg);
      xp_cnt_reg <= cnt_step(xp_cnt_reg);
      wtr_cnt_reg <= cnt_step(wtr_cnt_reg);
      rp_cnt_reg <= cnt_step(rp_cnt_reg);
      dal_cnt_reg <= cnt_step(dal_cnt_reg);
      spacing_err_reg <= spacing_hit;
      if (link.cke != cke_q_reg) begin
        cke_cnt_reg <= CNT_W'(CLOCK_GATE_MIN_WINDOW - 1);
        if (link.cke) begin
          xp_cnt_reg <= CNT_W'(POWERDOWN_EXIT_DELAY - 1);
        end
      end
      if (link.cmd == CMD_PRE) begin
        rp_cnt_reg <= CNT_W'(PRECHARGE_PERIOD_CYCLES - 1);
      end
      if (in_burst && last_beat) begin
        wtr_cnt_reg <= CNT_W'(WRITE_TO_READ_TURNAROUND);
        if (auto_pre_reg) begin
          dal_cnt_reg <= autoprecharge_write_delay(wr_field_reg);
        end
      end
    end
  end

  assign link.capt_err = capt_err_reg;
  assign wr_data = wr_data_reg;
  assign wr_valid = wr_valid_reg;
  assign spacing_err = spacing_err_reg;
  assign data_suspect = suspect_reg;
  assign strobe_single_ended = strobe_se_reg;
  assign wr_recovery = wr_field_reg;

endmodule

// ==== tb/dcs_link_properties.sv ====
// concurrent checks on the command link between the two ends
`timescale 1ns/100ps
module dcs_link_properties
  import dcs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic cke,
  input wire logic [CMD_W-1:0] cmd,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] dq,
  input wire logic dqs_t,
  input wire logic dqs_c,
  input wire logic capt_err
);
  localparam int RP_CYC = (PRECHARGE_PERIOD_PS + CLK_PERIOD_PS - 1)
                        / CLK_PERIOD_PS;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------
  // mode shadow and autoprecharge window, seen from the wire
  // ----------------------------------------------------------------
  logic se_reg;
  logic [MODE_WR_W-1:0] wr_field_reg;
  logic [CNT_W-1:0] dal_cnt_reg;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      se_reg <= MODE_STROBE_SE_RESET;
      wr_field_reg <= MODE_WR_RESET;
    end else if (cmd == CMD_MODE) begin
      se_reg <= addr[MODE_STROBE_SE_BIT];
      wr_field_reg <= addr[MODE_WR_LSB +: MODE_WR_W];
    end
  end

  // loaded one cycle late, so zero marks the first legal activate
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dal_cnt_reg <= '0;
    end else if (cmd == CMD_WRA) begin
      dal_cnt_reg <= CNT_W'(WR_BEATS + RP_CYC + 1) + CNT_W'(wr_field_reg);
    end else if (dal_cnt_reg != '0) begin
      dal_cnt_reg <= dal_cnt_reg - CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_WR_TO_RD: assert property (
    (cmd == CMD_WR || cmd == CMD_WRA) |=> (cmd != CMD_RD)[*4])
    else $error("read too soon after write burst");
  AST_CKE_HOLD: assert property ($changed(cke) |=> $stable(cke)[*2])
    else $error("clock gate changed inside hold window");
  AST_EXIT_TO_ACT: assert property (
    $rose(cke) |-> (cmd != CMD_ACT)[*2])
    else $error("activate too soon after clock gate rise");
  AST_PRE_TO_ACT: assert property (
    cmd == CMD_PRE |=> (cmd != CMD_ACT)[*2])
    else $error("activate too soon after precharge");
  AST_WRA_TO_ACT: assert property (cmd == CMD_ACT |-> dal_cnt_reg == '0)
    else $error("activate inside autoprecharge delay");
  AST_GATED_NOP: assert property (!cke |-> cmd == CMD_NOP)
    else $error("command sent with clock gate low");
  AST_BEAT0: assert property (
    ($past(cmd) == CMD_WR || $past(cmd) == CMD_WRA) |-> dqs_t && !dqs_c)
    else $error("first beat strobe pair wrong");
  AST_BEAT1: assert property (
    ($past(cmd, 2) == CMD_WR || $past(cmd, 2) == CMD_WRA)
      |-> !dqs_t && (dqs_c == !se_reg))
    else $error("second beat strobe pair wrong");
  AST_NO_CAPT_FAULT: assert property (!capt_err)
    else $error("capture fault on a clean link");

  COV_WRA: cover property (cmd == CMD_WRA);
  COV_PRE_ACT: cover property (cmd == CMD_PRE ##3 cmd == CMD_ACT);
  COV_CKE_FALL: cover property ($fell(cke));
  COV_SE_BEAT: cover property (se_reg && $past(cmd) == CMD_WR && dq != '0);
endmodule

// ==== tb/ddr2_command_spacing_rules_tb.sv ====
// self-checking bench joining controller end and device end
`timescale 1ns/100ps
module ddr2_command_spacing_rules_tb;
  import dcs_pkg::*;
  localparam int RP_CYC = (PRECHARGE_PERIOD_PS + CLK_PERIOD_PS - 1)
                        / CLK_PERIOD_PS;
  localparam int WTR_GAP = WR_BEATS + WRITE_TO_READ_TURNAROUND + 1;

  logic mclk = 1'b0;
  logic rst_b, req_valid, req_ready, cke_req, cke_ready, cke_q;
  logic [CMD_W-1:0] req_cmd;
  logic [ADDR_W-1:0] req_addr;
  logic [WR_BEATS*DATA_W-1:0] req_wdata, got_wr;
  logic rewrite_pending, ctrl_se, dev_se, wr_valid, spacing_err;
  logic data_suspect, spacing_err_b, data_suspect_b;
  logic [DATA_W-1:0] wr_data;
  logic [MODE_WR_W-1:0] wr_recovery;
  int miscompares = 0, check_count = 0, cyc = 0, err_seen = 0;
  int t_cke_up = 0, t_cke_dn = 0;
  int t_cmd [8];

  dcs_link_if lk();
  dcs_link_if lb();

  always #2.5 mclk = ~mclk;

  dcs_ctrl_end i_dcs_ctrl_end (.mclk(mclk), .rst_b(rst_b), .link(lk.ctrl),
    .req_valid(req_valid), .req_cmd(req_cmd), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .cke_req(cke_req),
    .cke_ready(cke_ready), .rewrite_pending(rewrite_pending),
    .strobe_single_ended(ctrl_se));
  dcs_dev_end i_dcs_dev_end (.mclk(mclk), .rst_b(rst_b), .link(lk.dev),
    .wr_data(wr_data), .wr_valid(wr_valid), .spacing_err(spacing_err),
    .data_suspect(data_suspect), .strobe_single_ended(dev_se),
    .wr_recovery(wr_recovery));
  // second device end faces the bench, which breaks the rules on purpose
  dcs_dev_end i_dcs_dev_end_b (.mclk(mclk), .rst_b(rst_b), .link(lb.dev),
    .wr_data(), .wr_valid(), .spacing_err(spacing_err_b),
    .data_suspect(data_suspect_b), .strobe_single_ended(),
    .wr_recovery());
  dcs_link_properties i_dcs_link_properties (.mclk(mclk), .rst_b(rst_b),
    .cke(lk.cke), .cmd(lk.cmd), .addr(lk.addr), .dq(lk.dq),
    .dqs_t(lk.dqs_t), .dqs_c(lk.dqs_c), .capt_err(lk.capt_err));

  // ----------------------------------------------------------------
  // link monitor: cycle stamps of commands and clock gate edges
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    cyc++;
    if (rst_b === 1'b1) begin
      if (lk.cmd !== CMD_NOP) t_cmd[lk.cmd] = cyc;
      if (lk.cke === 1'b1 && cke_q === 1'b0) t_cke_up = cyc;
      if (lk.cke === 1'b0 && cke_q === 1'b1) t_cke_dn = cyc;
      if (wr_valid === 1'b1) got_wr = {wr_data, got_wr[15:8]};
      if (spacing_err !== 1'b0) err_seen++;
    end
    cke_q = lk.cke;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    chk_val({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic tick();
    @(posedge mclk);
    #1;
  endtask

  // request stays up after return; caller lowers it or sends again
  task automatic send(input logic [CMD_W-1:0] c,
                      input logic [ADDR_W-1:0] a, input logic [15:0] d);
    req_valid = 1'b1;
    req_cmd = c;
    req_addr = a;
    req_wdata = d;
    repeat (64) begin
      @(negedge mclk);
      if (req_ready === 1'b1) break;
    end
    if (req_ready !== 1'b1) begin
      miscompares++;
      end_sim();
    end
    tick();
  endtask

  task automatic lb_wr(input logic good, input logic [15:0] d);
    lb.cmd = CMD_WR;
    tick();
    lb.cmd = CMD_NOP;
    lb.dq = d[7:0];
    lb.dqs_t = good;
    lb.dqs_c = !good;
    tick();
    lb.dq = d[15:8];
    lb.dqs_t = 1'b0;
    lb.dqs_c = 1'b1;
    tick();
    lb.dq = ~d[15:8];
    chk_flag(lb.capt_err, !good);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    chk_flag(lk.cke, 1'b0);
    chk_flag(lk.dqs_c, 1'b1);
    chk_val(16'(wr_recovery), 16'(MODE_WR_RESET));
    chk_flag(req_ready, 1'b0);
    $display("reset test done");
  endtask

  task automatic test_exit();
    cke_req = 1'b1;
    send(CMD_ACT, '0, '0);
    req_valid = 1'b0;
    tick();
    chk_val(16'(t_cmd[CMD_ACT] - t_cke_up),
            16'(POWERDOWN_EXIT_DELAY));
    $display("exit test done");
  endtask

  task automatic test_pre_act();
    send(CMD_PRE, '0, '0);
    send(CMD_ACT, '0, '0);
    req_valid = 1'b0;
    tick();
    chk_val(16'(t_cmd[CMD_ACT] - t_cmd[CMD_PRE]),
            16'(RP_CYC));
    $display("precharge test done");
  endtask

  task automatic test_modes();
    logic se;
    logic [2:0] f;
    logic [15:0] d;
    for (int i = 0; i < 2; i++) begin
      se = (i == 0);
      f = se ? 3'h7 : 3'h0;
      d = se ? 16'ha55a : 16'h3cc3;
      send(CMD_MODE, {f, se, 10'h000}, '0);
      send(CMD_WR, '0, d);
      send(CMD_RD, '0, '0);
      req_valid = 1'b0;
      tick();
      chk_flag(dev_se, se);
      chk_flag(ctrl_se, se);
      chk_val(16'(wr_recovery), 16'(f));
      chk_val(got_wr, d);
      chk_val(16'(t_cmd[CMD_RD] - t_cmd[CMD_WR]),
              16'(WTR_GAP));
    end
    $display("strobe mode test done");
  endtask

  task automatic test_wra();
    for (int f = 0; f < 8; f += 7) begin
      send(CMD_MODE, {3'(f), 1'b0, 10'h000}, '0);
      send(CMD_WRA, '0, 16'h0ff0);
      send(CMD_ACT, '0, '0);
      req_valid = 1'b0;
      tick();
      chk_val(16'(t_cmd[CMD_ACT] - t_cmd[CMD_WRA]),
              16'(WR_BEATS + f + 1 + RP_CYC + 1));
    end
    $display("autoprecharge test done");
  endtask

  task automatic test_cke_hold();
    cke_req = 1'b0;
    repeat (16) begin
      tick();
      if (lk.cke === 1'b0) break;
    end
    if (lk.cke !== 1'b0) begin
      miscompares++;
      end_sim();
    end
    chk_flag(cke_ready, 1'b0);
    cke_req = 1'b1;
    repeat (8) tick();
    chk_val(16'(t_cke_up - t_cke_dn),
            16'(CLOCK_GATE_MIN_WINDOW));
    chk_flag(lk.cke, 1'b1);
    chk_flag(cke_ready, 1'b1);
    $display("clock gate test done");
  endtask

  task automatic test_fault();
    lb_wr(1'b0, 16'h5aa5);
    tick();
    chk_flag(data_suspect_b, 1'b1);
    lb_wr(1'b1, 16'h5aa5);
    lb.cmd = CMD_RD;
    tick();
    lb.cmd = CMD_NOP;
    chk_flag(data_suspect_b, 1'b0);
    chk_flag(spacing_err_b, 1'b1);
    // gate bounced inside its hold window, then activate right on exit
    lb.cke = 1'b0;
    tick();
    lb.cke = 1'b1;
    tick();
    lb.cmd = CMD_ACT;
    chk_flag(spacing_err_b, 1'b1);
    tick();
    lb.cmd = CMD_NOP;
    chk_flag(spacing_err_b, 1'b1);
    $display("fault test done");
  endtask

  initial begin
    rst_b = 1'b0;
    req_valid = 1'b0;
    req_cmd = CMD_NOP;
    req_addr = '0;
    req_wdata = '0;
    cke_req = 1'b0;
    lb.cke = 1'b0;
    lb.cmd = CMD_NOP;
    lb.addr = '0;
    lb.dq = '0;
    lb.dqs_t = 1'b0;
    lb.dqs_c = 1'b1;
    repeat (16) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    lb.cke = 1'b1;
    test_reset();
    test_exit();
    test_pre_act();
    test_modes();
    test_wra();
    test_cke_hold();
    test_fault();
    chk_flag(data_suspect, 1'b0);
    chk_flag(rewrite_pending, 1'b0);
    chk_val(16'(err_seen), 16'h0000);
    end_sim();
  end
endmodule
